// File: src/aim_bank.sv
// register bank, conversion sequencer and totalizers of the analog inputs
`timescale 1ns/10ps

// Overview of operation
// R1: one shared converter visits eight channels in turn
// R2: each channel refreshed about twice per second
// R3: eight latest readings in input registers 1-8
// R4: input registers read-only, holding registers read/write
// R5: totals add each reading every sampling interval
// R6: 32-bit totals, odd register holds upper half
// R7: writable interval register sets accumulation period
// R8: mode 0 raw, 1 milliamp, 2 five-volt
// R9: supply voltage reported as tenths of volts
// R10: supply reading scaled by numerator over 65535
// R11: voltage mode shared numerator, current per channel
// R12: calibration kept in nonvolatile store, host-writable
// R13: three relaying registers: bases and block size
// R14: watchdog period counted in 10 ms steps
// R15: transmit enable leads data by 10 ms steps
// R16: speed index 0..5 selects line speed
// R17: status 0001h restart, 0002h link timeout
// R18: host leaves factory test registers alone
// R19: no valid message in period sets timeout
// R20: restart sets flag; write-one clears flags
module aim_bank #(
    parameter int unsigned STEP_CYCLES = aim_pkg::STEP_CYCLES,
    parameter int unsigned SLOT_CYCLES = aim_pkg::SLOT_CYCLES
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire aim_pkg::aim_req_t req_i,
    output aim_pkg::aim_ans_t ans_o,
    output logic [2:0] chan_sel_o,
    output logic conv_start_o,
    input wire logic conv_done_i,
    input wire logic [15:0] conv_data_i,
    input wire logic [15:0] supply_raw_i,
    input wire aim_pkg::aim_cal_t nv_cal_i,
    output aim_pkg::aim_nv_t nv_save_o,
    input wire logic msg_valid_i,
    input wire logic tx_req_i,
    input wire logic tx_done_i,
    output logic tx_en_o,
    output logic tx_go_o,
    output logic [2:0] line_speed_o,
    output aim_pkg::aim_relay_t relay_o
);

    typedef enum logic [1:0] {
        CV_WAIT = 2'b01,
        CV_BUSY = 2'b10
    } aim_cv_t;

    // numerator over 65535: (p + p>>16 + 1) >> 16 is exact for p < 2**32 - 1, so for any 16 by 16 product
    function automatic logic [15:0] aim_scale(input logic [15:0] raw,
                                              input logic [15:0] num);
        logic [31:0] p;
        logic [32:0] s;
        p = raw * num;
        s = {1'b0, p} + {17'h00000, p[31:16]} + 33'h000000001;
        return s[31:16];
    endfunction : aim_scale

    logic [23:0] step_cnt_q;
    logic tick_q;
    logic [23:0] slot_cnt_q;
    aim_cv_t cv_q;
    logic [2:0] ch_q;
    logic start_q;
    logic [15:0] reading_q [aim_pkg::CHANNELS];
    logic [31:0] total_q [aim_pkg::CHANNELS];
    logic [15:0] mode_q [aim_pkg::CHANNELS];
    logic [15:0] cur_cal_q [aim_pkg::CHANNELS];
    logic [15:0] interval_q, ivl_cnt_q;
    logic acc_q;
    logic [15:0] supply_cal_q, volt_cal_q, supply_v_q;
    logic [15:0] wdog_q, wd_cnt_q, txlead_q, lead_cnt_q, speed_q, cond_q;
    logic wd_fire;
    logic boot_q;
    logic tx_en_q, tx_go_q;
    aim_pkg::aim_relay_t relay_q;
    aim_pkg::aim_ans_t ans_q, ans_d;
    aim_pkg::aim_nv_t nv_q;
    logic hw;
    logic [15:0] num_sel, scaled;

    assign hw = req_i.wr & req_i.holding; // R4
    assign wd_fire = tick_q && wdog_q != 16'h0000
                     && wd_cnt_q + 16'h0001 >= wdog_q;

    // shared 10 ms time base for interval, watchdog and transmit lead
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            step_cnt_q <= 24'h000000;
            tick_q <= 1'b0;
        end else if (step_cnt_q == 24'(STEP_CYCLES - 1)) begin
            step_cnt_q <= 24'h000000;
            tick_q <= 1'b1;
        end else begin
            step_cnt_q <= step_cnt_q + 24'h000001;
            tick_q <= 1'b0;
        end
    end

    // slot timer paces the multiplexer: 16 slots a second, 2 per channel
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            slot_cnt_q <= 24'h000000;
            cv_q <= CV_WAIT;
            ch_q <= 3'h0;
            start_q <= 1'b0;
        end else begin
            start_q <= 1'b0;
            if (slot_cnt_q == 24'(SLOT_CYCLES - 1)) begin
                slot_cnt_q <= 24'h000000;
            end else begin
                slot_cnt_q <= slot_cnt_q + 24'h000001;
            end
            unique case (cv_q)
                CV_WAIT: begin
                    if (slot_cnt_q == 24'(SLOT_CYCLES - 1)) begin // R2
                        start_q <= 1'b1;
                        cv_q <= CV_BUSY;
                    end
                end
                CV_BUSY: begin
                    if (conv_done_i) begin
                        ch_q <= ch_q + 3'h1; // R1
                        cv_q <= CV_WAIT;
                    end
                end
                default: cv_q <= CV_WAIT;
            endcase
        end
    end

    // pick the numerator by mode of the channel being converted
    always_comb begin
        if (mode_q[ch_q] == aim_pkg::MODE_MA) begin
            num_sel = cur_cal_q[ch_q]; // R11
        end else begin
            num_sel = volt_cal_q; // R11
        end
        if (mode_q[ch_q] == aim_pkg::MODE_MA
            || mode_q[ch_q] == aim_pkg::MODE_5V) begin
            scaled = aim_scale(conv_data_i, num_sel); // R8
        end else begin
            scaled = conv_data_i; // R8
        end
    end

    // sampling interval counts 10 ms ticks; zero stops accumulation
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ivl_cnt_q <= 16'h0000;
            acc_q <= 1'b0;
        end else begin
            acc_q <= 1'b0;
            if (tick_q && interval_q != 16'h0000) begin
                if (ivl_cnt_q + 16'h0001 >= interval_q) begin // R7
                    ivl_cnt_q <= 16'h0000;
                    acc_q <= 1'b1;
                end else begin
                    ivl_cnt_q <= ivl_cnt_q + 16'h0001;
                end
            end
        end
    end

    // per-channel reading, mode, current numerator and running total
    for (genvar k = 0; k < aim_pkg::CHANNELS; k++) begin : g_chan
        localparam logic [8:0] HI = aim_pkg::TOTAL_FIRST + 9'(2 * k);
        localparam logic [8:0] MD = aim_pkg::MODE_FIRST + 9'(k);
        localparam logic [8:0] CC = aim_pkg::CUR_CAL_FIRST + 9'(k);
        always_ff @(posedge clk_i) begin
            if (!rstn_i) begin
                reading_q[k] <= 16'h0000;
            end else if (cv_q == CV_BUSY && conv_done_i
                         && ch_q == 3'(k)) begin
                reading_q[k] <= scaled; // R3
            end
        end
        // a host write to a half wins over that tick's addition
        always_ff @(posedge clk_i) begin
            if (!rstn_i) begin
                total_q[k] <= 32'h00000000;
            end else if (hw && req_i.addr == HI) begin
                total_q[k][31:16] <= req_i.wdata; // R6
            end else if (hw && req_i.addr == HI + 9'h001) begin
                total_q[k][15:0] <= req_i.wdata; // R6
            end else if (acc_q) begin
                total_q[k] <= total_q[k] + {16'h0000, reading_q[k]}; // R5
            end
        end
        always_ff @(posedge clk_i) begin
            if (!rstn_i) begin
                mode_q[k] <= aim_pkg::MODE_RST;
                cur_cal_q[k] <= aim_pkg::CAL_RST;
            end else if (boot_q) begin
                cur_cal_q[k] <= nv_cal_i.cur[k]; // R12
            end else if (hw && req_i.addr == MD) begin
                mode_q[k] <= req_i.wdata; // R8
            end else if (hw && req_i.addr == CC) begin
                cur_cal_q[k] <= req_i.wdata; // R11
            end
        end
    end

    // shared holding registers; calibration reloads once after reset
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            boot_q <= 1'b1;
            interval_q <= aim_pkg::INTERVAL_RST;
            supply_cal_q <= aim_pkg::CAL_RST;
            volt_cal_q <= aim_pkg::CAL_RST;
            relay_q <= {3{aim_pkg::RELAY_RST}};
            wdog_q <= aim_pkg::WDOG_RST;
            txlead_q <= aim_pkg::TXLEAD_RST;
            speed_q <= aim_pkg::SPEED_RST;
        end else if (boot_q) begin
            boot_q <= 1'b0;
            supply_cal_q <= nv_cal_i.supply; // R12
            volt_cal_q <= nv_cal_i.volt; // R12
        end else if (hw) begin
            unique case (req_i.addr)
                aim_pkg::INTERVAL_REG: interval_q <= req_i.wdata; // R7
                aim_pkg::SUPPLY_CAL_REG: supply_cal_q <= req_i.wdata; // R10
                aim_pkg::VOLT_CAL_REG: volt_cal_q <= req_i.wdata; // R11
                aim_pkg::RELAY_IN_REG: relay_q.in_base <= req_i.wdata; // R13
                aim_pkg::RELAY_OUT_REG: relay_q.out_base <= req_i.wdata; // R13
                aim_pkg::RELAY_SIZE_REG: relay_q.size <= req_i.wdata; // R13
                aim_pkg::WDOG_REG: wdog_q <= req_i.wdata; // R14
                aim_pkg::TXLEAD_REG: txlead_q <= req_i.wdata; // R15
                aim_pkg::SPEED_REG: begin
                    if (req_i.wdata <= aim_pkg::SPEED_MAX) begin
                        speed_q <= req_i.wdata; // R16
                    end
                end
                default: ;
            endcase
        end
    end

    // calibration writes are echoed to the nonvolatile store
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            nv_q <= '0;
        end else begin
            nv_q.valid <= hw && !boot_q
                && (req_i.addr == aim_pkg::SUPPLY_CAL_REG
                    || req_i.addr == aim_pkg::VOLT_CAL_REG
                    || (req_i.addr >= aim_pkg::CUR_CAL_FIRST
                        && req_i.addr <= aim_pkg::CUR_CAL_FIRST + 9'h007));
            nv_q.addr <= req_i.addr; // R12
            nv_q.data <= req_i.wdata;
        end
    end

    // supply reading is resampled every cycle through its numerator
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            supply_v_q <= 16'h0000;
        end else begin
            supply_v_q <= aim_scale(supply_raw_i, supply_cal_q); // R9 R10
        end
    end

    // watchdog counts ticks since the last good message; zero disables
    always_ff @(posedge clk_i) begin
        if (!rstn_i || msg_valid_i || wd_fire) begin
            wd_cnt_q <= 16'h0000; // R19
        end else if (tick_q && wdog_q != 16'h0000) begin
            wd_cnt_q <= wd_cnt_q + 16'h0001; // R14
        end
    end

    // condition flags: reset marks restart, set beats a same-cycle clear
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            cond_q <= aim_pkg::COND_RST; // R20
        end else begin
            cond_q <= (cond_q & ~((hw && req_i.addr == aim_pkg::COND_REG)
                                  ? req_i.wdata : 16'h0000)) // R20
                      | (wd_fire ? aim_pkg::COND_TIMEOUT : 16'h0000); // R17
        end
    end

    // transmit enable goes up first, or with data when the lead is zero; data follows after the lead time
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            tx_en_q <= 1'b0;
            tx_go_q <= 1'b0;
            lead_cnt_q <= 16'h0000;
        end else begin
            tx_go_q <= 1'b0;
            if (tx_done_i) begin
                tx_en_q <= 1'b0;
            end else if (tx_req_i && !tx_en_q) begin
                tx_en_q <= 1'b1;
                lead_cnt_q <= 16'h0000;
                tx_go_q <= txlead_q == 16'h0000;
            end else if (tx_en_q && tick_q && lead_cnt_q < txlead_q) begin
                lead_cnt_q <= lead_cnt_q + 16'h0001;
                tx_go_q <= lead_cnt_q + 16'h0001 == txlead_q; // R15
            end
        end
    end

    // read mux; the factory words read zero and refuse writes
    always_comb begin
        ans_d = '0;
        ans_d.valid = req_i.rd | req_i.wr;
        if (req_i.wr && !req_i.holding) begin
            ans_d.err = 1'b1; // R4
        end else if (req_i.holding) begin
            unique case (req_i.addr)
                aim_pkg::INTERVAL_REG: ans_d.rdata = interval_q;
                aim_pkg::SUPPLY_CAL_REG: ans_d.rdata = supply_cal_q;
                aim_pkg::VOLT_CAL_REG: ans_d.rdata = volt_cal_q;
                aim_pkg::RELAY_IN_REG: ans_d.rdata = relay_q.in_base;
                aim_pkg::RELAY_OUT_REG: ans_d.rdata = relay_q.out_base;
                aim_pkg::RELAY_SIZE_REG: ans_d.rdata = relay_q.size;
                aim_pkg::WDOG_REG: ans_d.rdata = wdog_q;
                aim_pkg::TXLEAD_REG: ans_d.rdata = txlead_q;
                aim_pkg::SPEED_REG: begin
                    ans_d.rdata = speed_q;
                    ans_d.err = req_i.wr && req_i.wdata > aim_pkg::SPEED_MAX;
                end
                aim_pkg::COND_REG: ans_d.rdata = cond_q; // R17
                aim_pkg::TEST_REG, aim_pkg::CTRL_REG: ans_d.err = req_i.wr; // R18
                default: ans_d.err = 1'b1;
            endcase
            for (int i = 0; i < aim_pkg::CHANNELS; i++) begin
                if (req_i.addr == aim_pkg::TOTAL_FIRST + 9'(2 * i)) begin
                    ans_d.rdata = total_q[i][31:16]; // R6
                    ans_d.err = 1'b0;
                end
                if (req_i.addr == aim_pkg::TOTAL_FIRST + 9'(2 * i + 1)) begin
                    ans_d.rdata = total_q[i][15:0];
                    ans_d.err = 1'b0;
                end
                if (req_i.addr == aim_pkg::MODE_FIRST + 9'(i)) begin
                    ans_d.rdata = mode_q[i];
                    ans_d.err = 1'b0;
                end
                if (req_i.addr == aim_pkg::CUR_CAL_FIRST + 9'(i)) begin
                    ans_d.rdata = cur_cal_q[i];
                    ans_d.err = 1'b0;
                end
            end
        end else begin
            unique case (req_i.addr)
                aim_pkg::SUPPLY_V_REG: ans_d.rdata = supply_v_q; // R9
                aim_pkg::FW_LEVEL_REG: ans_d.rdata = aim_pkg::FW_LEVEL;
                aim_pkg::MODEL_ID_REG: ans_d.rdata = aim_pkg::MODEL_ID;
                default: ans_d.err = 1'b1;
            endcase
            for (int i = 0; i < aim_pkg::CHANNELS; i++) begin
                if (req_i.addr == aim_pkg::READING_FIRST + 9'(i)) begin
                    ans_d.rdata = reading_q[i]; // R3
                    ans_d.err = 1'b0;
                end
            end
        end
    end

    // answer registered one cycle after the request
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ans_q <= '0;
        end else begin
            ans_q <= ans_d;
        end
    end

    assign ans_o = ans_q;
    assign chan_sel_o = ch_q;
    assign conv_start_o = start_q;
    assign nv_save_o = nv_q;
    assign tx_en_o = tx_en_q;
    assign tx_go_o = tx_go_q;
    assign line_speed_o = speed_q[2:0];
    assign relay_o = relay_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    a_ans_timing: assert property ((req_i.rd | req_i.wr) |=> ans_o.valid) // R4
        else $error("answer missing one cycle after request");
    a_ro_refused: assert property ((req_i.wr && !req_i.holding) // R4
        |=> ans_o.err) else $error("input register write not refused");
    a_restart_flag: assert property ($rose(rstn_i) |-> cond_q[0]) // R20
        else $error("restart flag not set after reset");
    a_timeout_sets: assert property (wd_fire |=> cond_q[1]) // R19
        else $error("timeout flag not set");
    a_set_wins: assert property ((wd_fire && hw // R17
        && req_i.addr == aim_pkg::COND_REG && req_i.wdata[1]) |=> cond_q[1])
        else $error("clear beat the timeout set");
    a_start_pulse: assert property (conv_start_o |=> !conv_start_o // R1
        ##0 cv_q == CV_BUSY) else $error("conversion start not a pulse");
    a_chan_step: assert property ((cv_q == CV_BUSY && conv_done_i) // R1
        |=> chan_sel_o == $past(chan_sel_o) + 3'h1)
        else $error("channel did not advance");
    a_acc_adds: assert property ((acc_q && !hw) |=> // R5
        total_q[0] == $past(total_q[0]) + {16'h0000, $past(reading_q[0])})
        else $error("total did not add the reading");
    a_speed_range: assert property (speed_q <= aim_pkg::SPEED_MAX) // R16
        else $error("speed index out of range");
    a_tx_order: assert property (tx_go_o |-> tx_en_o) // R15
        else $error("data released before transmit enable");
    a_reserved_zero: assert property ((req_i.rd && req_i.holding // R18
        && req_i.addr == aim_pkg::TEST_REG) |=> ans_o.rdata == 16'h0000)
        else $error("reserved word read not zero");

    c_conversion: cover property (cv_q == CV_BUSY && conv_done_i);
    c_accumulate: cover property (acc_q);
    c_timeout: cover property (wd_fire);
    c_tx_lead: cover property (tx_en_o ##1 tx_go_o);

endmodule : aim_bank

// File: src/aim_pkg.sv
// constants, register numbers and carrier types of the analog input bank
package aim_pkg;

    localparam int unsigned CHANNELS = 8;
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned STEP_MS = 10;
    localparam int unsigned STEP_CYCLES = STEP_MS * CLK_MHZ * 1000;
    localparam int unsigned SAMPLES_PER_S = 2;
    localparam int unsigned SLOT_CYCLES =
        (CLK_MHZ * 1000000) / (SAMPLES_PER_S * CHANNELS);

    // register numbers as seen by the host, one 16-bit word each
    localparam logic [8:0] READING_FIRST = 9'h001;
    localparam logic [8:0] TOTAL_FIRST = 9'h001;
    localparam logic [8:0] INTERVAL_REG = 9'h084;
    localparam logic [8:0] MODE_FIRST = 9'h085;
    localparam logic [8:0] SUPPLY_CAL_REG = 9'h095;
    localparam logic [8:0] VOLT_CAL_REG = 9'h096;
    localparam logic [8:0] CUR_CAL_FIRST = 9'h097;
    localparam logic [8:0] RELAY_IN_REG = 9'h0F5;
    localparam logic [8:0] RELAY_OUT_REG = 9'h0F6;
    localparam logic [8:0] RELAY_SIZE_REG = 9'h0F7;
    localparam logic [8:0] WDOG_REG = 9'h0F8;
    localparam logic [8:0] TXLEAD_REG = 9'h0F9;
    localparam logic [8:0] SUPPLY_V_REG = 9'h0FA;
    localparam logic [8:0] SPEED_REG = 9'h0FD;
    localparam logic [8:0] COND_REG = 9'h0FE;
    localparam logic [8:0] FW_LEVEL_REG = 9'h0FF;
    localparam logic [8:0] TEST_REG = 9'h0FF;
    localparam logic [8:0] MODEL_ID_REG = 9'h100;
    localparam logic [8:0] CTRL_REG = 9'h100;

    // values after reset, and the highest speed index
    localparam logic [15:0] INTERVAL_RST = 16'h0064;
    localparam logic [15:0] MODE_RST = 16'h0000;
    localparam logic [15:0] CAL_RST = 16'hFFFF;
    localparam logic [15:0] RELAY_RST = 16'h0000;
    localparam logic [15:0] WDOG_RST = 16'h0000;
    localparam logic [15:0] TXLEAD_RST = 16'h0000;
    localparam logic [15:0] SPEED_RST = 16'h0002;
    localparam logic [15:0] COND_RST = 16'h0001;
    localparam logic [15:0] SPEED_MAX = 16'h0005;

    // scaling modes and condition bits
    localparam logic [15:0] MODE_RAW = 16'h0000;
    localparam logic [15:0] MODE_MA = 16'h0001;
    localparam logic [15:0] MODE_5V = 16'h0002;
    localparam logic [15:0] COND_RESTART = 16'h0001;
    localparam logic [15:0] COND_TIMEOUT = 16'h0002;

    // identity words, values arbitrary
    localparam logic [15:0] FW_LEVEL = 16'h0100;
    localparam logic [15:0] MODEL_ID = 16'h0A5A;

    typedef struct packed {
        logic rd;
        logic wr;
        logic holding;
        logic [8:0] addr;
        logic [15:0] wdata;
    } aim_req_t;

    typedef struct packed {
        logic valid;
        logic err;
        logic [15:0] rdata;
    } aim_ans_t;

    typedef struct packed {
        logic valid;
        logic [8:0] addr;
        logic [15:0] data;
    } aim_nv_t;

    typedef struct packed {
        logic [15:0] supply;
        logic [15:0] volt;
        logic [7:0][15:0] cur;
    } aim_cal_t;

    typedef struct packed {
        logic [15:0] in_base;
        logic [15:0] out_base;
        logic [15:0] size;
    } aim_relay_t;

endpackage : aim_pkg

// File: tb/aim_conv_model.sv
// converter model answering the conversion starts of the bank
`timescale 1ns/10ps
module aim_conv_model (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [2:0] chan_sel_i,
    input wire logic start_i,
    output logic done_o,
    output logic [15:0] data_o
);
    logic busy_q;
    logic [1:0] wait_q;
    // fixed settling time; data toggles so only the done cycle is valid
    always_ff @(posedge clk_i) begin
        done_o <= 1'b0;
        data_o <= ~data_o;
        if (!rstn_i) begin
            busy_q <= 1'b0;
            wait_q <= 2'h0;
            data_o <= 16'h0000;
        end else if (start_i) begin
            busy_q <= 1'b1;
            wait_q <= 2'h3;
        end else if (busy_q) begin
            wait_q <= wait_q - 2'h1;
            if (wait_q == 2'h1) begin
                busy_q <= 1'b0;
                done_o <= 1'b1;
                data_o <= 16'h1000 + {13'h0000, chan_sel_i};
            end
        end
    end
endmodule : aim_conv_model

// File: tb/analog_input_register_map_tb.sv
// register-level testbench of the analog input bank
`timescale 1ns/10ps
module analog_input_register_map_tb;
    logic clk_i;
    logic rstn_i;
    aim_pkg::aim_req_t req_i;
    aim_pkg::aim_ans_t ans;
    aim_pkg::aim_cal_t cal;
    aim_pkg::aim_relay_t relay;
    logic [2:0] chan_sel;
    logic [2:0] speed;
    logic conv_start, conv_done, msg_valid, tx_req, tx_done, tx_en, tx_go;
    logic [15:0] conv_data;
    logic [15:0] supply_raw;
    logic [31:0] prod;
    logic [15:0] hi, lo;
    aim_pkg::aim_nv_t nv;
    int cnt;
    int error_cnt = 0;
    int samples_checked = 0;

    // short counts keep the run well under the cycle budget
    aim_bank #(.STEP_CYCLES(10), .SLOT_CYCLES(20)) u_aim_bank (
        .clk_i(clk_i), .rstn_i(rstn_i), .req_i(req_i), .ans_o(ans),
        .chan_sel_o(chan_sel), .conv_start_o(conv_start),
        .conv_done_i(conv_done), .conv_data_i(conv_data),
        .supply_raw_i(supply_raw), .nv_cal_i(cal), .nv_save_o(nv),
        .msg_valid_i(msg_valid), .tx_req_i(tx_req), .tx_done_i(tx_done),
        .tx_en_o(tx_en), .tx_go_o(tx_go), .line_speed_o(speed),
        .relay_o(relay));

    aim_conv_model u_aim_conv_model (
        .clk_i(clk_i), .rstn_i(rstn_i), .chan_sel_i(chan_sel),
        .start_i(conv_start), .done_o(conv_done), .data_o(conv_data));

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task final_report;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report

    task chk(input string name, input logic [15:0] exp,
             input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // one request held a full cycle; answer looked at one cycle later
    task acc(input logic wr, input logic hold, input logic [8:0] addr,
             input logic [15:0] wdata, input logic err,
             input logic [15:0] rexp);
        @(negedge clk_i);
        req_i = '{rd: ~wr, wr: wr, holding: hold, addr: addr, wdata: wdata};
        @(negedge clk_i);
        req_i.rd = 1'b0;
        req_i.wr = 1'b0;
        chk("valid", 16'h0001, {15'h0000, ans.valid});
        chk("err", {15'h0000, err}, {15'h0000, ans.err});
        if (!wr && !err) chk("rdata", rexp, ans.rdata);
    endtask : acc

    // holding read handing the word back for the caller to judge
    task peek(input logic [8:0] addr, output logic [15:0] d);
        @(negedge clk_i);
        req_i = '{rd: 1'b1, holding: 1'b1, addr: addr, default: '0};
        @(negedge clk_i);
        req_i.rd = 1'b0;
        chk("peek valid", 16'h0001, {15'h0000, ans.valid});
        d = ans.rdata;
    endtask : peek

    // hang guard, well above the expected run length
    initial begin
        repeat (4000) @(posedge clk_i);
        error_cnt++;
        final_report();
    end

    initial begin
        rstn_i = 1'b0;
        req_i = '0;
        {msg_valid, tx_req, tx_done} = 3'h0;
        supply_raw = 16'h008F;
        cal = '{supply: 16'hFFFF, volt: 16'hFFFF, cur: {8{16'h8000}}};
        repeat (16) @(negedge clk_i);
        rstn_i = 1'b1;
        repeat (2) @(negedge clk_i);
        acc(0, 1, aim_pkg::INTERVAL_REG, 16'h0000, 0, 16'h0064);
        acc(0, 1, aim_pkg::SPEED_REG, 16'h0000, 0, 16'h0002);
        acc(0, 1, aim_pkg::COND_REG, 16'h0000, 0, 16'h0001);
        acc(0, 1, aim_pkg::SUPPLY_CAL_REG, 16'h0000, 0, 16'hFFFF);
        acc(0, 0, aim_pkg::SUPPLY_V_REG, 16'h0000, 0, 16'h008F);
        $display("test reset values done");
        acc(1, 0, 9'h001, 16'h1234, 1, 16'h0000);
        // the host keeps off the factory words 255 and 256
        acc(1, 1, 9'h0A1, 16'h1234, 1, 16'h0000);
        acc(0, 1, 9'h0A0, 16'h0000, 1, 16'h0000);
        acc(1, 1, aim_pkg::SPEED_REG, 16'h0006, 1, 16'h0000);
        acc(0, 1, aim_pkg::SPEED_REG, 16'h0000, 0, 16'h0002);
        for (int i = 0; i < 6; i++) begin
            acc(1, 1, aim_pkg::SPEED_REG, 16'(i), 0, 16'h0000);
            chk("speed", 16'(i), {13'h0000, speed});
        end
        for (int i = 0; i < 3; i++) begin
            acc(1, 1, 9'(245 + i), 16'hA000 + 16'(i), 0, 16'h0000);
        end
        chk("in_base", 16'hA000, relay.in_base);
        chk("out_base", 16'hA001, relay.out_base);
        chk("size", 16'hA002, relay.size);
        $display("test refusals and config done");
        acc(1, 1, aim_pkg::INTERVAL_REG, 16'h0000, 0, 16'h0000);
        acc(1, 1, 9'h001, 16'h1234, 0, 16'h0000);
        acc(1, 1, 9'h002, 16'h5678, 0, 16'h0000);
        acc(0, 1, 9'h001, 16'h0000, 0, 16'h1234);
        acc(0, 1, 9'h002, 16'h0000, 0, 16'h5678);
        $display("test totals done");
        repeat (400) @(negedge clk_i);
        for (int i = 0; i < 8; i++) begin
            acc(0, 0, 9'(i + 1), 16'h0000, 0, 16'h1000 + 16'(i));
        end
        acc(1, 1, aim_pkg::MODE_FIRST + 9'h001, aim_pkg::MODE_MA, 0,
            16'h0000);
        acc(1, 1, aim_pkg::VOLT_CAL_REG, 16'h8000, 0, 16'h0000);
        chk("nv valid", 16'h0001, {15'h0000, nv.valid});
        chk("nv addr", {7'h00, aim_pkg::VOLT_CAL_REG},
            {7'h00, nv.addr});
        chk("nv data", 16'h8000, nv.data);
        acc(1, 1, aim_pkg::MODE_FIRST + 9'h002, aim_pkg::MODE_5V, 0,
            16'h0000);
        repeat (200) @(negedge clk_i);
        prod = (32'h0000_1001 * 32'h0000_8000) / 32'h0000_FFFF;
        acc(0, 0, 9'h002, 16'h0000, 0, prod[15:0]);
        prod = (32'h0000_1002 * 32'h0000_8000) / 32'h0000_FFFF;
        acc(0, 0, 9'h003, 16'h0000, 0, prod[15:0]);
        // one tick interval: channel 0 total grows by whole readings
        acc(1, 1, aim_pkg::INTERVAL_REG, 16'h0001, 0, 16'h0000);
        repeat (60) @(negedge clk_i);
        acc(1, 1, aim_pkg::INTERVAL_REG, 16'h0000, 0, 16'h0000);
        peek(9'h001, hi);
        peek(9'h002, lo);
        prod = {hi, lo} - 32'h1234_5678;
        chk("total step", 16'h0000, {4'h0, prod[11:0]});
        chk("total adds", 16'h0001,
            {15'h0000, prod[31:12] > 20'h3 && prod[31:12] < 20'h9});
        $display("test readings done");
        acc(1, 1, aim_pkg::COND_REG, 16'h0001, 0, 16'h0000);
        acc(0, 1, aim_pkg::COND_REG, 16'h0000, 0, 16'h0000);
        acc(1, 1, aim_pkg::WDOG_REG, 16'h0004, 0, 16'h0000);
        // messages every 16 cycles keep a 4-tick watchdog quiet
        repeat (10) begin
            msg_valid = 1'b1;
            @(negedge clk_i);
            msg_valid = 1'b0;
            repeat (15) @(negedge clk_i);
        end
        acc(0, 1, aim_pkg::COND_REG, 16'h0000, 0, 16'h0000);
        repeat (60) @(negedge clk_i);
        acc(0, 1, aim_pkg::COND_REG, 16'h0000, 0, 16'h0002);
        $display("test condition done");
        tx_req = 1'b1;
        @(negedge clk_i);
        tx_req = 1'b0;
        chk("tx_en", 16'h0001, {15'h0000, tx_en});
        chk("tx_go", 16'h0001, {15'h0000, tx_go});
        tx_done = 1'b1;
        @(negedge clk_i);
        tx_done = 1'b0;
        chk("tx_en off", 16'h0000, {15'h0000, tx_en});
        // a two-tick lead holds data back for 10 to 20 cycles
        acc(1, 1, aim_pkg::TXLEAD_REG, 16'h0002, 0, 16'h0000);
        tx_req = 1'b1;
        cnt = 0;
        @(negedge clk_i);
        tx_req = 1'b0;
        while (!tx_go && cnt < 40) begin
            @(negedge clk_i);
            cnt++;
        end
        chk("lead ticks", 16'h0001, {15'h0000, cnt > 8 && cnt < 22});
        chk("lead tx_en", 16'h0001, {15'h0000, tx_en});
        $display("test transmit done");
        final_report();
    end
endmodule : analog_input_register_map_tb
